// ===== ext_cache_ctrl.sv
`timescale 1ns/1ps
`include "ecc_consts.svh"

module ext_cache_ctrl
	import ecc_pkg::*;
(
	input  wire logic         clock,
	input  wire logic         rst,
	input  wire logic         hsel,
	input  wire logic [31:0]  haddr,
	input  wire logic [1:0]   htrans,
	input  wire logic         hwrite,
	input  wire logic [2:0]   hsize,
	input  wire logic [31:0]  hwdata,
	input  wire logic         hready,
	output logic              hreadyout,
	output logic              hresp,
	output logic [31:0]       hrdata,
	output logic              irq,
	input  wire logic         fill_err,
	input  wire logic         tag_err,
	input  wire logic         spar_err,
	input  wire logic         abr_pin,
	input  wire logic         cack_pin,
	input  wire logic         sysclk_pin,
	input  wire logic         block32,
	output logic              abr_eff,
	output logic              cack_eff,
	output logic              machine_check,
	input  wire logic [39:0]  sys_ca,
	output logic              sys_ca_par,
	input  wire logic         wr_en_in,
	input  wire logic [127:0] wr_data_in,
	input  wire logic [4:0]   wr_tag_in,
	output logic              wr_en_out,
	output logic [127:0]      wr_data_out,
	output logic [4:0]        wr_tag_out,
	input  wire logic         rd_req,
	output logic              rd_start,
	output logic              rd_valid,
	input  wire logic [7:0]   cnt1_ev,
	input  wire logic [7:0]   cnt2_ev,
	output logic              pm_inc1,
	output logic              pm_inc2,
	input  wire logic         vb_need_wb,
	input  wire logic         vb_empty,
	output logic              vb_flush_all,
	output logic              vb_write_one
);

	state_s       s_reg;
	state_s       s_next;
	logic         ap;
	logic         tk;
	logic [1:0]   wave;
	logic [3:0]   ival;
	logic [2:0]   ev;
	logic [2:0]   clr;
	logic [127:0] inj;
	logic         ev1_sel;
	logic         ev2_sel;
	logic [28:0]  c;

	assign c         = s_reg.ctrl;
	assign ap        = hsel & htrans[1] & hready;
	assign tk        = s_reg.sy2[`P_SCLK] & ~s_reg.tk;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = s_reg.rdata;
	assign irq       = |(s_reg.st & s_reg.mask);

	// Wave pipelining is forced off for 32-byte block systems
	assign wave = s_reg.sy2[`P_B32] ? 2'h0 : c[`F_WAVE_HI:`F_WAVE_LO];
	assign ival = s_reg.rdlat - {2'h0, wave};

	assign rd_start = rd_req & c[`F_EN] & (s_reg.gap == 4'h0);
	assign rd_valid = s_reg.vp[s_reg.rdlat - 4'h1];

	assign abr_eff  = c[`F_PIPE] ? s_reg.pl[0] : s_reg.sy2[`P_ABR];
	assign cack_eff = c[`F_PIPE] ? s_reg.pl[1] : s_reg.sy2[`P_CACK];

	assign machine_check = s_reg.mchk;
	assign sys_ca_par    = s_reg.cpar;
	assign wr_en_out     = s_reg.we;
	assign wr_data_out   = s_reg.wd;
	assign wr_tag_out    = s_reg.wt;
	assign pm_inc1       = s_reg.pm[0];
	assign pm_inc2       = s_reg.pm[1];

	assign ev1_sel = cnt1_ev[c[`F_PM1_HI:`F_PM1_LO]];
	assign ev2_sel = cnt2_ev[c[`F_PM2_HI:`F_PM2_LO]];

	assign vb_flush_all = (s_reg.vb == VB_FLUSH);
	assign vb_write_one = vb_need_wb & (c[`F_VB] | c[`F_EN]) & (s_reg.vb == VB_IDLE);

	// One flipped bit per quadword is correctable, two are not
	always_comb begin
		inj             = '0;
		inj[0]          = c[`F_INJ0];
		inj[`QW]        = c[`F_INJ0];
		inj[1]          = c[`F_INJ1];
		inj[`QW + 1]    = c[`F_INJ1];
	end

	// Accepted check errors; ignored ones leave no trace at all
	always_comb begin
		ev            = '0;
		ev[`EV_FILL]  = s_reg.sy2[`P_FILL] & ~c[`F_IGN];
		ev[`EV_TAG]   = s_reg.sy2[`P_TAG] & ~c[`F_IGN];
		ev[`EV_SPAR]  = s_reg.sy2[`P_SPAR] & ~c[`F_IGN] & ~c[`F_SPD];
	end

	assign clr = (s_reg.aw && s_reg.aa == `A_STAT) ? hwdata[`EV_W-1:0] : 3'h0;

	always_comb begin
		s_next = s_reg;
		s_next.sy1 = {block32, sysclk_pin, cack_pin, abr_pin, spar_err, tag_err, fill_err};
		s_next.sy2 = s_reg.sy1;
		s_next.tk  = s_reg.sy2[`P_SCLK];
		// Extra stage loads only on a rising system clock
		if (tk) begin
			s_next.pl = {s_reg.sy2[`P_CACK], s_reg.sy2[`P_ABR]};
		end

		s_next.aw = ap & hwrite;
		s_next.aa = haddr[7:0];
		if (ap && !hwrite) begin
			case (haddr[7:0])
				`A_STAT:  s_next.rdata = {29'h0, s_reg.st};
				`A_MASK:  s_next.rdata = {29'h0, s_reg.mask};
				`A_STATE: s_next.rdata = {26'h0, s_reg.vb == VB_FLUSH, s_reg.mchk,
					s_reg.gap != 4'h0, cack_eff, abr_eff, c[`F_EN]};
				default:  s_next.rdata = 32'h0;
			endcase
		end
		if (s_reg.aw) begin
			case (s_reg.aa)
				`A_CTRL: s_next.ctrl = hwdata[`CTRL_W-1:0];
				`A_CFG:  s_next.rdlat = hwdata[`F_LAT_HI:`F_LAT_LO];
				`A_MASK: s_next.mask = hwdata[`EV_W-1:0];
				default: ;
			endcase
		end
		// A new event wins over a clear in the same cycle
		s_next.st   = (s_reg.st & ~clr) | ev;
		s_next.mchk = |ev;

		s_next.cpar = ^sys_ca;

		s_next.we = wr_en_in;
		s_next.wd = wr_data_in ^ inj;
		if (c[`F_FHIT] && c[`F_EN]) begin
			s_next.wt = c[`F_TAG_HI:`F_TAG_LO];
		end else begin
			s_next.wt = wr_tag_in;
		end

		if (rd_start) begin
			s_next.gap = ival - 4'h1;
		end else if (s_reg.gap != 4'h0) begin
			s_next.gap = s_reg.gap - 4'h1;
		end
		s_next.vp = {s_reg.vp[14:0], rd_start};

		s_next.pm = {ev2_sel, ev1_sel};

		case (s_reg.vb)
			VB_IDLE: begin
				if (vb_need_wb && !c[`F_EN] && !c[`F_VB]) begin
					s_next.vb = VB_FLUSH;
				end
			end
			VB_FLUSH: begin
				if (vb_empty) begin
					s_next.vb = VB_IDLE;
				end
			end
			default: s_next.vb = VB_IDLE;
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_reg       <= '0;
			s_reg.ctrl  <= `CTRL_RST;
			s_reg.rdlat <= `LAT_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	property p_tag;
		wr_en_in && c[`F_FHIT] && c[`F_EN] |=> wr_tag_out == $past(c[`F_TAG_HI:`F_TAG_LO]);
	endproperty
	a_tag: assert property (p_tag) else $error("forced tag not written");

	property p_inv;
		wr_en_in && c[`F_INJ0] |=> wr_data_out[`QW] != $past(wr_data_in[`QW]);
	endproperty
	a_inv: assert property (p_inv) else $error("bit 64 not inverted");

	property p_ign;
		c[`F_IGN] |=> !machine_check;
	endproperty
	a_ign: assert property (p_ign) else $error("ignored error raised check");

	property p_lat;
		rd_start && s_reg.rdlat == 4'h4 && !s_reg.aw |-> ##4 rd_valid;
	endproperty
	a_lat: assert property (p_lat) else $error("read data not valid at latency");

	property p_gap;
		rd_start && ival == 4'h5 |=> !rd_start [*4];
	endproperty
	a_gap: assert property (p_gap) else $error("read started before interval");

	property p_mon;
		1'b1 |=> pm_inc1 == $past(ev1_sel) && pm_inc2 == $past(ev2_sel);
	endproperty
	a_mon: assert property (p_mon) else $error("monitor event mismatch");

	property p_vb;
		s_reg.vb == VB_IDLE && vb_need_wb && !c[`F_EN] && !c[`F_VB] |=> vb_flush_all;
	endproperty
	a_vb: assert property (p_vb) else $error("victim flush not started");

	property p_spd;
		c[`F_SPD] && !s_reg.st[`EV_SPAR] |=> !s_reg.st[`EV_SPAR];
	endproperty
	a_spd: assert property (p_spd) else $error("parity checked while disabled");

	property p_pipe;
		c[`F_PIPE] && !tk && !s_reg.aw |=> abr_eff == $past(abr_eff);
	endproperty
	a_pipe: assert property (p_pipe) else $error("latched pin moved off tick");

	property p_wave;
		s_reg.sy2[`P_B32] |-> ival == s_reg.rdlat;
	endproperty
	a_wave: assert property (p_wave) else $error("wave used in 32-byte system");

	property p_inv1;
		wr_en_in && c[`F_INJ1] |=> wr_data_out[1] != $past(wr_data_in[1]);
	endproperty
	a_inv1: assert property (p_inv1) else $error("bit 1 not inverted");

	property p_tag_pass;
		wr_en_in && !c[`F_FHIT] |=> wr_tag_out == $past(wr_tag_in);
	endproperty
	a_tag_pass: assert property (p_tag_pass) else $error("tag forced outside hit mode");

	property p_mchk;
		s_reg.sy2[`P_FILL] && !c[`F_IGN] |=> machine_check;
	endproperty
	a_mchk: assert property (p_mchk) else $error("fill error raised no check");

	property p_par;
		1'b1 |=> sys_ca_par == ^$past(sys_ca);
	endproperty
	a_par: assert property (p_par) else $error("address parity not generated");

	property p_valid;
		rd_start && s_reg.rdlat == 4'h7 && !s_reg.aw |-> ##7 rd_valid;
	endproperty
	a_valid: assert property (p_valid) else $error("read data not valid at latency 7");

	property p_flush_end;
		vb_flush_all && vb_empty |=> !vb_flush_all;
	endproperty
	a_flush_end: assert property (p_flush_end) else $error("flush did not end");

	property p_write_one;
		vb_need_wb && c[`F_VB] && !vb_flush_all |-> vb_write_one;
	endproperty
	a_write_one: assert property (p_write_one) else $error("single write-back missing");

	property p_spar;
		s_reg.sy2[`P_SPAR] && !c[`F_IGN] && !c[`F_SPD] |=> s_reg.st[`EV_SPAR];
	endproperty
	a_spar: assert property (p_spar) else $error("address parity error not flagged");

endmodule // ext_cache_ctrl

// ===== ecc_consts.svh
`ifndef ECC_CONSTS_SVH
`define ECC_CONSTS_SVH

// Register byte addresses (haddr[7:0])
`define A_CTRL      8'h00
`define A_CFG       8'h04
`define A_STAT      8'h08
`define A_MASK      8'h0c
`define A_STATE     8'h10

// Reset values
`define CTRL_RST    29'h00008070
`define LAT_RST     4'h4

// Control field positions
`define F_EN        0
`define F_FHIT      7
`define F_TAG_LO    8
`define F_TAG_HI    12
`define F_INJ0      13
`define F_INJ1      14
`define F_IGN       15
`define F_PIPE      16
`define F_WAVE_LO   17
`define F_WAVE_HI   18
`define F_PM1_LO    19
`define F_PM1_HI    21
`define F_PM2_LO    22
`define F_PM2_HI    24
`define F_VB        26
`define F_SPD       28
`define CTRL_W      29

// Configuration field positions
`define F_LAT_LO    4
`define F_LAT_HI    7

// Second quadword offset for injected bits
`define QW          64

// Event bits of status and mask
`define EV_FILL     0
`define EV_TAG      1
`define EV_SPAR     2
`define EV_W        3

// Synchronised pin positions
`define P_FILL      0
`define P_TAG       1
`define P_SPAR      2
`define P_ABR       3
`define P_CACK      4
`define P_SCLK      5
`define P_B32       6
`define P_W         7

`endif

// ===== ecc_pkg.sv
package ecc_pkg;

	typedef enum logic {
		VB_IDLE,
		VB_FLUSH
	} vb_state_e;

	typedef struct packed {
		logic [28:0]  ctrl;
		logic [3:0]   rdlat;
		logic [2:0]   st;
		logic [2:0]   mask;
		logic         aw;
		logic [7:0]   aa;
		logic [31:0]  rdata;
		logic [6:0]   sy1;
		logic [6:0]   sy2;
		logic         tk;
		logic [1:0]   pl;
		logic         we;
		logic [127:0] wd;
		logic [4:0]   wt;
		logic [3:0]   gap;
		logic [15:0]  vp;
		logic [1:0]   pm;
		vb_state_e    vb;
		logic         mchk;
		logic         cpar;
	} state_s;

endpackage

// ===== ext_cache_model.sv
`timescale 1ns/1ps
module ext_cache_model (
	input  wire logic clock,
	input  wire logic rst,
	output logic      sysclk_pin,
	output logic      abr_pin,
	output logic      cack_pin
);
	logic [2:0] div_reg;
	// System side runs at one eighth of the CPU rate
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			div_reg <= 3'h0;
		end else begin
			div_reg <= div_reg + 3'h1;
		end
	end
	assign sysclk_pin = div_reg[2];
	assign abr_pin    = div_reg[2] & div_reg[1];
	assign cack_pin   = ~div_reg[2] & div_reg[1];
endmodule // ext_cache_model

// ===== external_cache_control_upper_fields_tb.sv
`timescale 1ns/1ps
`include "ecc_consts.svh"
module external_cache_control_upper_fields_tb
	import ecc_pkg::*;
;
	logic         clock, rst, hsel, hwrite, hreadyout, hresp, irq, block32;
	logic [31:0]  haddr, hwdata, hrdata;
	logic [1:0]   htrans;
	logic [2:0]   hsize;
	logic         fill_err, tag_err, spar_err, abr_pin, cack_pin, sysclk_pin;
	logic         abr_eff, cack_eff, machine_check, sys_ca_par, wr_en_in, wr_en_out;
	logic [39:0]  sys_ca;
	logic [127:0] wr_data_in, wr_data_out;
	logic [4:0]   wr_tag_in, wr_tag_out;
	logic         rd_req, rd_start, rd_valid, pm_inc1, pm_inc2;
	logic [7:0]   cnt1_ev, cnt2_ev;
	logic         vb_need_wb, vb_empty, vb_flush_all, vb_write_one;
	int           fail_count = 0;
	int           check_count = 0;
	int           cyc = 0;

	ext_cache_ctrl i_ext_cache_ctrl (.clock, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .irq, .fill_err, .tag_err,
		.spar_err, .abr_pin, .cack_pin, .sysclk_pin, .block32, .abr_eff, .cack_eff,
		.machine_check, .sys_ca, .sys_ca_par, .wr_en_in, .wr_data_in, .wr_tag_in, .wr_en_out,
		.wr_data_out, .wr_tag_out, .rd_req, .rd_start, .rd_valid, .cnt1_ev, .cnt2_ev, .pm_inc1,
		.pm_inc2, .vb_need_wb, .vb_empty, .vb_flush_all, .vb_write_one);
	ext_cache_model i_ext_cache_model (.clock, .rst, .sysclk_pin, .abr_pin, .cack_pin);

	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	task close_out();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fail_count++;
			close_out();
		end
	end

	task chk(input logic [127:0] got, input logic [127:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge clock); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clock); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, e);
		chk(hresp, 1'b0);
	endtask

	task hit(input logic m);
		{fill_err, tag_err, spar_err} <= 3'h7;
		@(posedge clock);
		{fill_err, tag_err, spar_err} <= 3'h0;
		repeat (2) @(posedge clock);
		#1;
		chk(machine_check, m);
		repeat (4) @(posedge clock);
	endtask

	task t_pin(input logic p, input int e);
		int n;
		n = 0;
		@(posedge clock);
		wr(`A_CTRL, p ? 32'h0001_0000 : 32'h0);
		repeat (2) @(posedge clock);
		for (int k = 0; k < 16; k++) begin
			#1;
			if (abr_eff === 1'b1) n++;
			@(posedge clock);
		end
		chk(n, e);
		$display("pin latch done");
	endtask

	task t_wp(input logic [31:0] c, input logic [127:0] d, input logic [4:0] t, input logic p);
		@(posedge clock);
		wr(`A_CTRL, c);
		wr_en_in <= 1'b1;
		wr_tag_in <= 5'h0a;
		cnt1_ev <= 8'h08;
		cnt2_ev <= 8'h01;
		@(posedge clock);
		wr_en_in <= 1'b0;
		cnt1_ev <= 8'h00;
		cnt2_ev <= 8'h00;
		#1;
		chk(wr_data_out, d);
		chk(wr_tag_out, t);
		chk(pm_inc1, p);
		chk(pm_inc2, 1'b1);
		$display("write path done");
	endtask

	task t_err();
		@(posedge clock);
		rd(`A_CTRL, 32'h0);
		rd(8'h20, 32'h0);
		wr(`A_MASK, 32'h7);
		wr(`A_CTRL, 32'h0000_8000);
		hit(1'b0);
		rd(`A_STAT, 32'h0);
		wr(`A_CTRL, 32'h1000_0000);
		sys_ca <= 40'h7;
		hit(1'b1);
		rd(`A_STAT, 32'h3);
		#1;
		chk(irq, 1'b1);
		chk(sys_ca_par, 1'b1);
		@(posedge clock);
		wr(`A_MASK, 32'h0);
		#1;
		chk(irq, 1'b0);
		@(posedge clock);
		wr(`A_CTRL, 32'h0);
		hit(1'b1);
		rd(`A_STAT, 32'h7);
		wr(`A_STAT, 32'h7);
		rd(`A_STAT, 32'h0);
		$display("error path done");
	endtask

	task t_rd(input logic b, input int gap);
		int s0, s1, v0;
		s0 = -1;
		s1 = -1;
		v0 = -1;
		@(posedge clock);
		block32 <= b;
		wr(`A_CFG, 32'h70);
		wr(`A_CTRL, 32'h0004_0001);
		rd_req <= 1'b1;
		for (int n = 0; n < 20; n++) begin
			#1;
			if (rd_start === 1'b1) begin
				if (s0 < 0) s0 = n;
				else if (s1 < 0) s1 = n;
			end
			if (rd_valid === 1'b1 && v0 < 0) v0 = n;
			@(posedge clock);
		end
		rd_req <= 1'b0;
		repeat (10) @(posedge clock);
		chk(s1 - s0, gap);
		chk(v0 - s0, 7);
		$display("read timing done");
	endtask

	task t_vb();
		@(posedge clock);
		wr(`A_CTRL, 32'h0);
		vb_need_wb <= 1'b1;
		@(posedge clock);
		vb_need_wb <= 1'b0;
		#1;
		chk(vb_flush_all, 1'b1);
		@(posedge clock);
		vb_empty <= 1'b1;
		wr(`A_CTRL, 32'h0400_0000);
		vb_need_wb <= 1'b1;
		#1;
		chk(vb_write_one, 1'b1);
		chk(vb_flush_all, 1'b0);
		$display("victim done");
	endtask

	initial begin
		{hsel, haddr, htrans, hwrite, hwdata, fill_err, tag_err, spar_err, block32} = '0;
		{sys_ca, wr_en_in, wr_data_in, wr_tag_in, rd_req, cnt1_ev, cnt2_ev} = '0;
		{vb_need_wb, vb_empty} = 2'h0;
		hsize = 3'h2;
		rst = 1'b1;
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		hsel <= 1'b1;
		t_wp(32'h0018_7581, {64'h3, 64'h3}, 5'h15, 1'b1);
		t_wp(32'h0000_2001, {64'h1, 64'h1}, 5'h0a, 1'b0);
		t_err();
		t_rd(1'b0, 5);
		t_rd(1'b1, 7);
		t_vb();
		t_pin(1'b1, 0);
		t_pin(1'b0, 4);
		close_out();
	end
endmodule // external_cache_control_upper_fields_tb
